//--- src/cpu_register_file.sv
// Execute-side register file with status word, fetch queue and instruction cache.
//
// Summary of operation
// - Separate 32-bit address and data buses.
// - Transfers are word, half-word or byte.
// - Byte and half operands widen to words.
// - Unsigned widening fills upper bits with zeros.
// - Signed widening copies bit 7 or 15.
// - Prefetched bytes sit in eight-byte queue.
// - Instruction cache holds 64 words.
// - Memory fetch data fills queue and cache.
// - Cached instruction data avoids external reads.
// - Sixteen 32-bit registers plus working registers.
// - Arithmetic unit is 33 bits wide.
// - All registers but r15 are operands.
// - r11, r13, r14 written only in kernel.
// - Working registers unreachable by operands.
// - General registers need no level check.
// - r0 to r2 may be scratch.
// - r9 holds the frame pointer.
// - r10 holds the argument pointer.
// - Upper status word field layout.
// - Lower status word field layout.
// - Unused status bits always read zero.
// - Mode codes kernel, executive, supervisor, user.
// - Interrupt taken only above priority level; the code accepts IRQ_NMI at any level.
//
// The Wishbone interface to the registers and the register addresses were decided locally.
`include "cpu_regfile_map.svh"
`default_nettype none

module cpu_register_file
	import cpu_regfile_pkg::*;
(
	// Clock and reset.
	input  wire logic        SYS_CLK,
	input  wire logic        RST_N,
	// Wishbone slave.
	input  wire logic        WB_CYC_I,
	input  wire logic        WB_STB_I,
	input  wire logic        WB_WREN_I,
	input  wire logic [7:0]  WB_ADR_I,
	input  wire logic [3:0]  WB_SEL_I,
	input  wire logic [31:0] WB_DAT_I,
	output logic      [31:0] WB_DAT_O,
	output logic             WB_ACK_O,
	// External instruction memory.
	output logic      [31:0] MEM_ADDR,
	output logic             MEM_RD,
	output logic      [1:0]  MEM_SIZE,
	input  wire logic [31:0] MEM_DATA,
	input  wire logic        MEM_ACK,
	// Interrupt priority check.
	input  wire logic [3:0]  IRQ_LEVEL,
	input  wire logic        IRQ_NMI,
	output logic             IRQ_ACCEPT,
	// Fault report.
	output logic             PRIV_FAULT
);

	// ============================================================
	// State and functions

	rf_state_t st_ff;       // Registered state.
	rf_state_t nxt_st;      // Next state.

	logic [1:0][31:0] raw_op;   // Unwidened operands a and b.
	logic [1:0][31:0] wide_op;  // Widened operands a and b.

	// True for registers that only kernel level may write.
	function automatic logic is_privileged(input logic [3:0] idx);
		return (idx == `IDX_STATUS_WORD) || (idx == `IDX_BLOCK_POINTER) ||
			(idx == `IDX_INT_STACK);
	endfunction

	// Merges write data under the byte selects.
	function automatic logic [31:0] merge_sel(input logic [31:0] old_v,
		input logic [31:0] new_v, input logic [3:0] sel);
		logic [31:0] res;
		res = old_v;
		for (int k = 0; k < 4; k++) begin
			if (sel[k]) begin
				res[8*k +: 8] = new_v[8*k +: 8];
			end
		end
		return res;
	endfunction

	// Status word write: unused bits stay zero, save flag and trace mask read only.
	function automatic logic [31:0] status_write(input logic [31:0] old_v,
		input logic [31:0] new_v);
		return {6'h00, new_v[`SW_FLUSH_DIS_BIT:`SW_PREV_MODE_LSB],
			old_v[`SW_REG_SAVE_BIT], new_v[`SW_INIT_CTX_BIT:`SW_STATE_CODE_LSB],
			old_v[`SW_TRACE_MASK_BIT], new_v[`SW_EXC_TYPE_MSB:`SW_EXC_TYPE_LSB]};
	endfunction

	// Records an exception in the status word and drops the trace mask.
	function automatic logic [31:0] raise(input logic [31:0] sw, input logic [3:0] code);
		logic [31:0] res;
		res = sw;
		res[`SW_STATE_CODE_MSB:`SW_STATE_CODE_LSB] = code;
		res[`SW_EXC_TYPE_MSB:`SW_EXC_TYPE_LSB] = `EXC_NORMAL;
		res[`SW_TRACE_MASK_BIT] = 1'b0;
		return res;
	endfunction

	// ============================================================
	// Operand widening

	// Operand sources come straight from the command word being written.
	assign raw_op[0] = st_ff.regs[WB_DAT_I[7:4]];
	assign raw_op[1] = st_ff.regs[WB_DAT_I[11:8]];

	// One widener per operand.
	genvar g;
	for (g = 0; g < 2; g++) begin : g_widen
		operand_widener u_widen (
			.raw       (raw_op[g]),
			.size      (size_t'(WB_DAT_I[16:15])),
			.is_signed (WB_DAT_I[17]),
			.wide      (wide_op[g])
		);
	end

	// ============================================================
	// Next-state logic

	always_comb begin
		logic        take;          // Request accepted this cycle.
		logic        wr;            // Accepted write.
		logic        kernel;        // Current level is kernel.
		logic [3:0]  idx;           // Register addressed on the bus.
		logic        pc_load;       // Program counter rewritten.
		logic        push;          // Fetched word enters the queue.
		logic [31:0] push_word;     // Word entering the queue.
		logic        pop;           // Queue byte read out.
		logic [5:0]  line;          // Cache index of the fetch address.
		logic        hit;           // Fetch address present in the cache.
		logic [32:0] res;           // Arithmetic unit result.
		logic        ovf;           // Signed overflow.
		logic [3:0]  rd;            // Arithmetic destination.
		logic [31:0] sw;            // Status word being built.
		logic [4:0]  sh;            // Shift count.
		logic [63:0] rot;           // Rotate helper.
		take      = WB_CYC_I & WB_STB_I & ~st_ff.ack;
		wr        = take & WB_WREN_I;
		kernel    = mode_t'(st_ff.regs[`IDX_STATUS_WORD][`SW_CUR_MODE_MSB:`SW_CUR_MODE_LSB])
			== MODE_KERNEL;
		idx       = WB_ADR_I[5:2];
		pc_load   = 1'b0;
		push      = 1'b0;
		push_word = MEM_DATA;
		pop       = 1'b0;
		line      = st_ff.fetch_addr[7:2];
		hit       = st_ff.cache_valid[line] &&
			(st_ff.cache_tag[line] == st_ff.fetch_addr[31:8]) &&
			!st_ff.regs[`IDX_STATUS_WORD][`SW_CACHE_DIS_BIT];
		res       = 33'h0_0000_0000;
		ovf       = 1'b0;
		rd        = WB_DAT_I[3:0];
		sw        = st_ff.regs[`IDX_STATUS_WORD];
		sh        = wide_op[1][4:0];
		rot       = {wide_op[0], wide_op[0]} << sh;
		nxt_st    = st_ff;

		// Classic single cycle: ack follows one cycle after the strobe, then drops.
		nxt_st.ack        = take;
		nxt_st.priv_fault = 1'b0;

		// Read data; unmapped addresses answer with zero.
		if (take && !WB_WREN_I) begin
			if (WB_ADR_I[7:6] == `GPR_WINDOW_TOP) begin
				nxt_st.dat_o = st_ff.regs[idx];
			end else if (WB_ADR_I == `ALU_CMD_ADDR) begin
				nxt_st.dat_o = st_ff.alu_cmd;
			end else if (WB_ADR_I == `QUEUE_DATA_ADDR) begin
				pop          = (st_ff.q_count != 4'h0);
				nxt_st.dat_o = {23'h000000, pop, st_ff.queue[st_ff.q_rd]};
			end else if (WB_ADR_I == `FETCH_STATUS_ADDR) begin
				nxt_st.dat_o = {st_ff.hit_count, 11'h000, st_ff.fstate == F_MEM,
					st_ff.q_count};
			end else begin
				nxt_st.dat_o = 32'h0000_0000;
			end
		end

		// Register writes over the bus.
		if (wr && WB_ADR_I[7:6] == `GPR_WINDOW_TOP) begin
			if (is_privileged(idx) && !kernel) begin
				sw                = raise(sw, `CODE_PRIV_REGISTER);
				nxt_st.priv_fault = 1'b1;
			end else if (idx == `IDX_STATUS_WORD) begin
				sw = status_write(sw, merge_sel(sw, WB_DAT_I, WB_SEL_I));
			end else begin
				// General and pointer registers other than r13 and r14 need no level check.
				nxt_st.regs[idx] = merge_sel(st_ff.regs[idx], WB_DAT_I, WB_SEL_I);
				pc_load          = (idx == `IDX_PROG_COUNTER);
				// A new control block means a new process: flush unless disabled.
				if (idx == `IDX_BLOCK_POINTER && !sw[`SW_FLUSH_DIS_BIT]) begin
					nxt_st.cache_valid = '0;
				end
			end
		end

		// Arithmetic command: execute at once on the written word.
		if (wr && WB_ADR_I == `ALU_CMD_ADDR) begin
			nxt_st.alu_cmd          = WB_DAT_I;
			sw[`SW_TRACE_MASK_BIT]  = 1'b1;
			// The program counter is never an operand.
			if (WB_DAT_I[7:4] == `IDX_PROG_COUNTER || WB_DAT_I[11:8] == `IDX_PROG_COUNTER ||
				rd == `IDX_PROG_COUNTER) begin
				sw = raise(sw, `CODE_INVALID_DESC);
			end else if (is_privileged(rd) && !kernel) begin
				sw                = raise(sw, `CODE_PRIV_REGISTER);
				nxt_st.priv_fault = 1'b1;
			end else begin
				// 33-bit datapath: the top bit is the carry.
				unique case (alu_op_t'(WB_DAT_I[14:12]))
					OP_ADD: res = {1'b0, wide_op[0]} + {1'b0, wide_op[1]};
					OP_SUB: res = {1'b0, wide_op[0]} - {1'b0, wide_op[1]};
					OP_AND: res = {1'b0, wide_op[0] & wide_op[1]};
					OP_OR:  res = {1'b0, wide_op[0] | wide_op[1]};
					OP_XOR: res = {1'b0, wide_op[0] ^ wide_op[1]};
					OP_SHL: res = {1'b0, wide_op[0]} << sh;
					OP_SHR: res = {1'b0, wide_op[0] >> sh};
					OP_ROL: res = {1'b0, rot[63:32]};
				endcase
				if (alu_op_t'(WB_DAT_I[14:12]) == OP_ADD) begin
					ovf = (wide_op[0][31] == wide_op[1][31]) && (res[31] != wide_op[0][31]);
				end else if (alu_op_t'(WB_DAT_I[14:12]) == OP_SUB) begin
					ovf = (wide_op[0][31] != wide_op[1][31]) && (res[31] != wide_op[0][31]);
				end
				// The result is also kept in the internal working register.
				nxt_st.work_result = res[31:0];
				if (rd == `IDX_STATUS_WORD) begin
					sw = status_write(sw, res[31:0]);
				end else begin
					nxt_st.regs[rd] = res[31:0];
					sw[`SW_FLAGS_MSB:`SW_FLAGS_LSB] = {res[31], res[31:0] == 32'h0, ovf,
						res[32]};
				end
				// Overflow trap is taken once and then disarmed.
				if (ovf && sw[`SW_OVF_TRAP_BIT]) begin
					sw                   = raise(sw, `CODE_INT_OVERFLOW);
					sw[`SW_OVF_TRAP_BIT] = 1'b0;
				end
				// Optional copy of the widened operand into scratch register r2.
				if (WB_DAT_I[18] && rd != `IDX_SCRATCH) begin
					nxt_st.regs[`IDX_SCRATCH] = wide_op[0];
				end
			end
		end
		nxt_st.regs[`IDX_STATUS_WORD] = {6'h00, sw[`SW_UNUSED_LSB-1:0]};

		// Queue read side.
		if (pop) begin
			nxt_st.q_rd = st_ff.q_rd + 3'h1;
		end

		// Fetch sequencer: one word at a time while four bytes are free.
		unique case (st_ff.fstate)
			F_IDLE: begin
				if (!pc_load && st_ff.q_count <= `QUEUE_ROOM_NEEDED) begin
					if (hit) begin
						// Cached word goes to the queue, no bus read.
						push               = 1'b1;
						push_word          = st_ff.cache_data[line];
						nxt_st.fetch_addr  = st_ff.fetch_addr + `WORD_STEP;
						nxt_st.hit_count   = st_ff.hit_count + 16'h0001;
					end else begin
						nxt_st.fstate   = F_MEM;
						nxt_st.mem_addr = st_ff.fetch_addr;
					end
				end
			end
			F_MEM: begin
				if (pc_load) begin
					nxt_st.discard = 1'b1;
				end
				if (MEM_ACK) begin
					// Fill the cache unless it is disabled; a stale word is still valid
					// for its address, so only the queue drops it.
					if (!sw[`SW_CACHE_DIS_BIT]) begin
						nxt_st.cache_valid[st_ff.mem_addr[7:2]] = 1'b1;
						nxt_st.cache_tag[st_ff.mem_addr[7:2]]   = st_ff.mem_addr[31:8];
						nxt_st.cache_data[st_ff.mem_addr[7:2]]  = MEM_DATA;
					end
					push              = !(st_ff.discard || pc_load);
					// A dropped word must not advance past the new program counter.
					nxt_st.fetch_addr = (pc_load || st_ff.discard) ? nxt_st.fetch_addr :
						st_ff.fetch_addr + `WORD_STEP;
					nxt_st.discard    = 1'b0;
					nxt_st.fstate     = F_IDLE;
				end
			end
		endcase

		// Queue write side, lowest address byte first.
		if (push) begin
			for (int k = 0; k < 4; k++) begin
				nxt_st.queue[3'(st_ff.q_wr + 3'(k))] = push_word[8*k +: 8];
			end
			nxt_st.q_wr = st_ff.q_wr + 3'h4;
		end
		nxt_st.q_count = st_ff.q_count + (push ? 4'h4 : 4'h0) - (pop ? 4'h1 : 4'h0);

		// A new program counter restarts the fetch stream.
		if (pc_load) begin
			nxt_st.fetch_addr = {WB_DAT_I[31:2], 2'b00};
			nxt_st.q_rd       = 3'h0;
			nxt_st.q_wr       = 3'h0;
			nxt_st.q_count    = 4'h0;
		end

		// Maskable requests must beat the level; level zero never asks.
		nxt_st.irq_accept = IRQ_NMI ||
			(IRQ_LEVEL > sw[`SW_PRIO_MSB:`SW_PRIO_LSB]);

		// Synchronous reset: everything clear, kernel level, fetch idle.
		if (!RST_N) begin
			nxt_st                        = '0;
			nxt_st.regs[`IDX_STATUS_WORD] = `STATUS_WORD_RESET;
			nxt_st.fstate                 = F_IDLE;
		end
	end

	// ============================================================
	// State register

	// Every register updates on every edge.
	always_ff @(posedge SYS_CLK) begin
		st_ff <= nxt_st;
	end

	// ============================================================
	// Outputs

	assign WB_DAT_O   = st_ff.dat_o;
	assign WB_ACK_O   = st_ff.ack;
	assign MEM_ADDR   = st_ff.mem_addr;
	assign MEM_RD     = (st_ff.fstate == F_MEM);
	assign MEM_SIZE   = `SIZE_WORD; // Instruction fetches always move whole words.
	assign IRQ_ACCEPT = st_ff.irq_accept;
	assign PRIV_FAULT = st_ff.priv_fault;

endmodule

`default_nettype wire

//--- include/cpu_regfile_map.svh
// Register offsets, status word field positions, codes and reset values of the register file.
`ifndef CPU_REGFILE_MAP_SVH
`define CPU_REGFILE_MAP_SVH

// ============================================================
// Bus register offsets (byte addresses, one word each; GPR_WINDOW_TOP is the value of address bits 7:6)
`define GPR_WINDOW_TOP     2'h0
`define ALU_CMD_ADDR       8'h40
`define QUEUE_DATA_ADDR    8'h44
`define FETCH_STATUS_ADDR  8'h48

// ============================================================
// Register indices of the dedicated registers
`define IDX_SCRATCH        4'h2
`define IDX_FRAME_POINTER  4'h9
`define IDX_ARG_POINTER    4'hA
`define IDX_STATUS_WORD    4'hB
`define IDX_BLOCK_POINTER  4'hD
`define IDX_INT_STACK      4'hE
`define IDX_PROG_COUNTER   4'hF

// ============================================================
// Status word field positions
`define SW_UNUSED_LSB      26
`define SW_FLUSH_DIS_BIT   25
`define SW_QUICK_INT_BIT   24
`define SW_CACHE_DIS_BIT   23
`define SW_OVF_TRAP_BIT    22
`define SW_FLAGS_MSB       21
`define SW_FLAGS_LSB       18
`define SW_TRACE_EN_BIT    17
`define SW_PRIO_MSB        16
`define SW_PRIO_LSB        13
`define SW_CUR_MODE_MSB    12
`define SW_CUR_MODE_LSB    11
`define SW_PREV_MODE_MSB   10
`define SW_PREV_MODE_LSB   9
`define SW_REG_SAVE_BIT    8
`define SW_INIT_CTX_BIT    7
`define SW_STATE_CODE_MSB  6
`define SW_STATE_CODE_LSB  3
`define SW_TRACE_MASK_BIT  2
`define SW_EXC_TYPE_MSB    1
`define SW_EXC_TYPE_LSB    0

// ============================================================
// Exception codes
`define EXC_NORMAL         2'h3
`define CODE_INVALID_DESC  4'h4
`define CODE_INT_OVERFLOW  4'h9
`define CODE_PRIV_REGISTER 4'hF

// ============================================================
// Sizes, codes and reset values
`define SIZE_BYTE          2'h0
`define SIZE_HALF          2'h1
`define SIZE_WORD          2'h2
`define QUEUE_BYTES        8
`define QUEUE_ROOM_NEEDED  4'h4
`define CACHE_WORDS        64
`define CACHE_TAG_BITS     24
`define STATUS_WORD_RESET  32'h0000_0000
`define WORD_STEP          32'h0000_0004

`endif

//--- include/cpu_regfile_pkg.sv
// Types shared by the register file and its operand widener.
`include "cpu_regfile_map.svh"
`default_nettype none

package cpu_regfile_pkg;

	// ============================================================
	// Enumerations

	// Execution level held in the current and previous mode fields.
	typedef enum logic [1:0] {
		MODE_KERNEL     = 2'h0,
		MODE_EXECUTIVE  = 2'h1,
		MODE_SUPERVISOR = 2'h2,
		MODE_USER       = 2'h3
	} mode_t;

	// Transfer size of an operand.
	typedef enum logic [1:0] {
		SZ_BYTE = `SIZE_BYTE,
		SZ_HALF = `SIZE_HALF,
		SZ_WORD = `SIZE_WORD
	} size_t;

	// Fetch sequencer, one-hot.
	typedef enum logic [1:0] {
		F_IDLE = 2'b01,
		F_MEM  = 2'b10
	} fetch_state_t;

	// Arithmetic unit operations.
	typedef enum logic [2:0] {
		OP_ADD = 3'h0,
		OP_SUB = 3'h1,
		OP_AND = 3'h2,
		OP_OR  = 3'h3,
		OP_XOR = 3'h4,
		OP_SHL = 3'h5,
		OP_SHR = 3'h6,
		OP_ROL = 3'h7
	} alu_op_t;

	// ============================================================
	// Whole state of the register file.
	typedef struct packed {
		logic [15:0][31:0]                              regs;
		logic [31:0]                                    work_result;
		logic [`CACHE_WORDS-1:0]                        cache_valid;
		logic [`CACHE_WORDS-1:0][`CACHE_TAG_BITS-1:0]   cache_tag;
		logic [`CACHE_WORDS-1:0][31:0]                  cache_data;
		logic [`QUEUE_BYTES-1:0][7:0]                   queue;
		logic [2:0]                                     q_rd;
		logic [2:0]                                     q_wr;
		logic [3:0]                                     q_count;
		logic [31:0]                                    fetch_addr;
		fetch_state_t                                   fstate;
		logic                                           discard;
		logic [31:0]                                    mem_addr;
		logic [31:0]                                    alu_cmd;
		logic [15:0]                                    hit_count;
		logic [31:0]                                    dat_o;
		logic                                           ack;
		logic                                           priv_fault;
		logic                                           irq_accept;
	} rf_state_t;

endpackage

`default_nettype wire

//--- src/operand_widener.sv
// Widens a byte or half-word operand to a full word with zero or sign fill.
`default_nettype none

module operand_widener
	import cpu_regfile_pkg::*;
(
	// Operand in.
	input  wire logic [31:0] raw,
	input  wire size_t       size,
	input  wire logic        is_signed,
	// Operand out.
	output logic      [31:0] wide
);

	// ============================================================
	// Widening

	// Unsigned fills with zeros, signed copies bit 7 or bit 15 upward.
	always_comb begin
		unique case (size)
			SZ_BYTE: wide = {{24{is_signed & raw[7]}}, raw[7:0]};
			SZ_HALF: wide = {{16{is_signed & raw[15]}}, raw[15:0]};
			default: wide = raw;
		endcase
	end

endmodule

`default_nettype wire

//--- testbench/cpu_register_file_sva.sv
// Checker of the register file port timing, bound to the top module.
`default_nettype none

module cpu_register_file_chk (
	// Clock and reset.
	input wire logic        SYS_CLK,
	input wire logic        RST_N,
	// Register bus.
	input wire logic        WB_CYC_I,
	input wire logic        WB_STB_I,
	input wire logic        WB_WREN_I,
	input wire logic        WB_ACK_O,
	// Fetch link.
	input wire logic [31:0] MEM_ADDR,
	input wire logic        MEM_RD,
	input wire logic [1:0]  MEM_SIZE,
	input wire logic        MEM_ACK,
	// Interrupt and fault.
	input wire logic [3:0]  IRQ_LEVEL,
	input wire logic        IRQ_NMI,
	input wire logic        IRQ_ACCEPT,
	input wire logic        PRIV_FAULT
);
	timeunit 1ns;
	timeprecision 1ns;
	// ============================================================
	// Helpers
	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (!RST_N);
	// A write request held on the bus; faults may only follow one.
	wire logic wr_req;
	assign wr_req = WB_CYC_I & WB_STB_I & WB_WREN_I;

	// ============================================================
	// Properties
	property p_ack_next; WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O; endproperty
	a_ack_next: assert property (p_ack_next) else $error("ack late");
	property p_ack_pulse; WB_ACK_O |=> !WB_ACK_O; endproperty
	a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
	property p_rd_hold; MEM_RD && !MEM_ACK |=> MEM_RD && $stable(MEM_ADDR); endproperty
	a_rd_hold: assert property (p_rd_hold) else $error("fetch dropped");
	property p_rd_drop; MEM_RD && MEM_ACK |=> !MEM_RD; endproperty
	a_rd_drop: assert property (p_rd_drop) else $error("fetch stays");
	property p_word; MEM_RD |-> MEM_SIZE == 2'h2 && MEM_ADDR[1:0] == 2'h0; endproperty
	a_word: assert property (p_word) else $error("fetch not word");
	property p_nmi; IRQ_NMI |=> IRQ_ACCEPT; endproperty
	a_nmi: assert property (p_nmi) else $error("nmi refused");
	property p_none; !IRQ_NMI && IRQ_LEVEL == 4'h0 |=> !IRQ_ACCEPT; endproperty
	a_none: assert property (p_none) else $error("idle accepted");
	property p_fault; PRIV_FAULT |-> $past(wr_req) ##1 !PRIV_FAULT; endproperty
	a_fault: assert property (p_fault) else $error("bad fault");

	// ============================================================
	// Coverage of the main traffic.
	c_fetch: cover property (MEM_RD && MEM_ACK);
	c_fault: cover property (PRIV_FAULT);
	c_irq: cover property (IRQ_ACCEPT && !IRQ_NMI);
endmodule

bind cpu_register_file cpu_register_file_chk cpu_register_file_chk_inst (.SYS_CLK, .RST_N,
	.WB_CYC_I, .WB_STB_I, .WB_WREN_I, .WB_ACK_O, .MEM_ADDR, .MEM_RD, .MEM_SIZE, .MEM_ACK,
	.IRQ_LEVEL, .IRQ_NMI, .IRQ_ACCEPT, .PRIV_FAULT);

`default_nettype wire

//--- testbench/instr_memory_model.sv
// Behavioural external instruction memory answering word reads.
`default_nettype none

module instr_memory_model (
	// Clock and reset.
	input  wire logic        clk,
	input  wire logic        rst_n,
	// Read request and answer.
	input  wire logic [31:0] mem_addr,
	input  wire logic        mem_rd,
	input  wire logic [3:0]  wait_cycles,
	output var  logic [31:0] mem_data,
	output var  logic        mem_ack
);
	timeunit 1ns;
	timeprecision 1ns;
	// Contents are the address scrambled with a fixed pattern.
	localparam logic [31:0] MIX = 32'hC3A5_5A3C;
	logic [3:0] cnt_ff; // Wait states spent on the current read.

	// ============================================================
	// One read at a time; data is valid in the ack cycle and inverted in the cycle after it,
	// then toggled on every idle cycle and held while wait states are spent.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			mem_ack <= 1'b0;
			cnt_ff <= 4'h0;
			mem_data <= 32'h0;
		end else if (mem_ack) begin
			mem_ack <= 1'b0;
			mem_data <= ~mem_data;
		end else if (mem_rd) begin
			if (cnt_ff >= wait_cycles) begin
				mem_ack <= 1'b1;
				mem_data <= mem_addr ^ MIX;
				cnt_ff <= 4'h0;
			end else begin
				cnt_ff <= cnt_ff + 4'h1;
			end
		end else begin
			mem_data <= ~mem_data;
		end
	end
endmodule

`default_nettype wire

//--- testbench/test_cpu_register_file.sv
// Self-checking bench of the register file with its memory model.
`default_nettype none

module test_cpu_register_file
	import cpu_regfile_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;

	// ============================================================
	// Signals
	logic        clk = 0, rst_n = 0, cyc = 0, stb = 0, wren = 0, nmi = 0;
	logic [7:0]  adr = 8'h0;
	logic [3:0]  sel = 4'h0, lvl = 4'h0, mem_wait = 4'h0;
	logic [31:0] dat = 32'h0, rdat, q, mdata, maddr;
	logic [1:0]  msize;
	logic        ack, mrd, mack, accept, fault;
	int          num_errors = 0, n_tests = 0, nflt = 0, rd0 = 0, cycles = 0;

	always #25 clk = ~clk;

	cpu_register_file cpu_register_file_inst (.SYS_CLK(clk), .RST_N(rst_n), .WB_CYC_I(cyc),
		.WB_STB_I(stb), .WB_WREN_I(wren), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dat),
		.WB_DAT_O(rdat), .WB_ACK_O(ack), .MEM_ADDR(maddr), .MEM_RD(mrd), .MEM_SIZE(msize),
		.MEM_DATA(mdata), .MEM_ACK(mack), .IRQ_LEVEL(lvl), .IRQ_NMI(nmi),
		.IRQ_ACCEPT(accept), .PRIV_FAULT(fault));
	instr_memory_model instr_memory_model_inst (.clk(clk), .rst_n(rst_n), .mem_addr(maddr),
		.mem_rd(mrd), .wait_cycles(mem_wait), .mem_data(mdata), .mem_ack(mack));

	// ============================================================
	// Monitors: fault pulses, memory reads of word 0, and a hang limit.
	always @(posedge clk) begin
		if (fault === 1'b1) nflt++;
		if (mrd === 1'b1 && mack === 1'b1 && maddr === 32'h0) rd0++;
		if (++cycles == 20000) begin
			num_errors++;
			end_sim();
		end
	end

	// ============================================================
	// Shared tasks
	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		n_tests++;
		if (s !== e) begin
			num_errors++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, s);
		end
	endtask

	// Classic cycle: hold everything until ack is sampled high.
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		{cyc, stb, wren, adr, dat, sel} <= {1'b1, 1'b1, w, a, d, 4'hF};
		do @(posedge clk); while (ack !== 1'b1);
		q = rdat;
		{cyc, stb} <= 2'b00;
	endtask

	task automatic end_sim();
		$display("comparisons %0d mismatches %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask

	// Waits for a full queue, then pops eight bytes of words 0 and 4.
	task automatic pop_two_words(input string n);
		for (int i = 0; i < 60 && q[3:0] !== 4'h8; i++) wb(0, 8'h48, 0);
		chk({n, " count"}, {28'h0, q[3:0]}, 32'h8);
		if (n == "hit") chk("hits", {16'h0, q[31:16]}, 32'h2);
		for (int i = 0; i < 8; i++) begin
			wb(0, 8'h44, 0);
			chk(n, q, 32'h100 | (((i / 4 * 4) ^ 32'hC3A5_5A3C) >> (8 * (i % 4))) & 32'hFF);
		end
	endtask

	// ============================================================
	// Scenarios
	task automatic t_fetch();
		pop_two_words("miss");
		chk("fetch size", {30'h0, msize}, 32'h2);
		mem_wait <= 4'h3;
		wb(1, 8'h3C, 32'h0);
		pop_two_words("hit");
		chk("word0 reads", rd0, 1);
	endtask

	task automatic t_regs();
		wb(1, 8'h0C, 32'h1111_0003);
		wb(1, 8'h24, 32'h0000_9000);
		wb(1, 8'h28, 32'h0000_A000);
		wb(0, 8'h0C, 0); chk("r3", q, 32'h1111_0003);
		wb(0, 8'h24, 0); chk("r9", q, 32'h0000_9000);
		wb(0, 8'h28, 0); chk("r10", q, 32'h0000_A000);
	endtask

	// Widens r5 through an OR with r0 into r6, with a copy into r2.
	task automatic t_widen();
		logic [1:0]  sz[5] = '{SZ_BYTE, SZ_BYTE, SZ_HALF, SZ_HALF, SZ_WORD};
		logic        sg[5] = '{0, 1, 0, 1, 1};
		logic [31:0] ex[5] = '{32'h80, 32'hFFFF_FF80, 32'h8080, 32'hFFFF_8080, 32'h8080};
		wb(1, 8'h00, 32'h0);
		wb(1, 8'h14, 32'h0000_8080);
		for (int i = 0; i < 5; i++) begin
			wb(1, 8'h40, {13'h0, 1'b1, sg[i], sz[i], 3'h3, 4'h0, 4'h5, 4'h6});
			wb(0, 8'h18, 0); chk("widened", q, ex[i]);
			wb(0, 8'h08, 0); chk("scratch", q, ex[i]);
		end
	endtask

	task automatic irq(input logic [3:0] l, input logic n, input logic e);
		@(posedge clk);
		{lvl, nmi} <= {l, n};
		repeat (2) @(posedge clk);
		chk("accept", {31'h0, accept}, {31'h0, e});
	endtask

	task automatic t_priv();
		irq(4'h1, 0, 1);
		wb(1, 8'h2C, 32'hFC01_F800);
		wb(0, 8'h2C, 0); chk("status", q, 32'h0001_F804);
		irq(4'hF, 0, 0);
		irq(4'h0, 1, 1);
		irq(4'h0, 0, 0);
		wb(1, 8'h34, 32'h0000_1234);
		@(posedge clk);
		chk("faults", nflt, 1);
		wb(0, 8'h34, 0); chk("r13", q, 32'h0);
		wb(0, 8'h2C, 0); chk("status fault", q, 32'h0001_F87B);
		wb(1, 8'h10, 32'h0000_0044);
		wb(0, 8'h10, 0); chk("user r4", q, 32'h44);
	endtask

	// ============================================================
	// Main sequence.
	initial begin
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		t_fetch();
		t_regs();
		t_widen();
		t_priv();
		end_sim();
	end
endmodule

`default_nettype wire
